// *** core/fbmcu_pkg.sv ***
// Constants, types and register map of the 4-bit controller core.
// Assumes an APB master with 32-bit data and a 200 MHz system clock.
package fbmcu_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int PC_W        = 9;
   localparam int NIB_W       = 4;
   localparam int PTR_W       = 6;
   localparam int OCT_W       = 8;
   localparam int DMEM_AW     = 5;
   localparam int DMEM_DEPTH  = 32;
   localparam int APB_AW      = 8;
   localparam int APB_DW      = 32;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [APB_AW-1:0] REG_OP    = 8'h00;
   localparam logic [APB_AW-1:0] REG_CORE  = 8'h04;
   localparam logic [APB_AW-1:0] REG_IO    = 8'h08;
   localparam logic [APB_AW-1:0] REG_STACK = 8'h0C;
   localparam logic [APB_AW-1:0] REG_CFG   = 8'h10;
   localparam logic [APB_AW-1:0] REG_HOLD  = 8'h14;

   // ------------------------------------------------------------
   // Operation codes
   // ------------------------------------------------------------
   localparam logic [4:0] OP_NOP  = 5'h00;
   localparam logic [4:0] OP_ASC  = 5'h01;
   localparam logic [4:0] OP_ADD  = 5'h02;
   localparam logic [4:0] OP_AISC = 5'h03;
   localparam logic [4:0] OP_CLRA = 5'h04;
   localparam logic [4:0] OP_COMP = 5'h05;
   localparam logic [4:0] OP_RC   = 5'h06;
   localparam logic [4:0] OP_SC   = 5'h07;
   localparam logic [4:0] OP_XOR  = 5'h08;
   localparam logic [4:0] OP_JMP  = 5'h09;
   localparam logic [4:0] OP_JP   = 5'h0A;
   localparam logic [4:0] OP_JSRP = 5'h0B;
   localparam logic [4:0] OP_JSR  = 5'h0C;
   localparam logic [4:0] OP_RET  = 5'h0D;
   localparam logic [4:0] OP_RETSK= 5'h0E;
   localparam logic [4:0] OP_JID  = 5'h0F;
   localparam logic [4:0] OP_LQID = 5'h10;
   localparam logic [4:0] OP_CAMQ = 5'h11;
   localparam logic [4:0] OP_CQMA = 5'h12;
   localparam logic [4:0] OP_LD   = 5'h13;
   localparam logic [4:0] OP_XCH_INC    = 5'h14;
   localparam logic [4:0] OP_XCH_DEC    = 5'h15;
   localparam logic [4:0] OP_SWAP_SHIFT = 5'h16;
   localparam logic [4:0] OP_LOAD_FEAT  = 5'h17;
   localparam logic [4:0] OP_LBI  = 5'h18;
   localparam logic [4:0] OP_OBD  = 5'h19;
   localparam logic [4:0] OP_OMG  = 5'h1A;
   localparam logic [4:0] OP_INL  = 5'h1B;
   localparam logic [4:0] OP_STII = 5'h1C;

   // ------------------------------------------------------------
   // Paging, reset and timing
   // ------------------------------------------------------------
   localparam logic [1:0]  PAGE_PAIR23   = 2'h1;
   localparam logic [2:0]  JSRP_PAGE     = 3'h2;
   localparam logic [3:0]  DIGIT_TOP     = 4'hF;
   localparam logic [3:0]  DIGIT_BOTTOM  = 4'h0;
   localparam logic [1:0]  PIN_LOW_TICKS = 2'h3;
   localparam int          POR_TICKS     = 2500;
   localparam logic [1:0]  DIV_SEL_16    = 2'h0;
   localparam logic [1:0]  DIV_SEL_8     = 2'h1;
   localparam logic [3:0]  DIV16_LAST    = 4'hF;
   localparam logic [3:0]  DIV8_LAST     = 4'h7;
   localparam logic [3:0]  DIV4_LAST     = 4'h3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] imm;
      logic [4:0] code;
   } fbmcu_op_s;

   typedef enum logic [2:0] {
      INIT_POR = 3'b001,
      INIT_PIN = 3'b010,
      INIT_RUN = 3'b100
   } fbmcu_init_e;

endpackage

// *** core/fbmcu_dmem.sv ***
// Data memory: 32 digits of 4 bits, registered read data.
// Assumes one write port and one read address on the core clock.
`timescale 1ns/1ps
module fbmcu_dmem
   import fbmcu_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               we,
   input  wire logic [DMEM_AW-1:0] addr,
   input  wire logic [NIB_W-1:0]   wdata,
   output logic      [NIB_W-1:0]   rdata_q
);

   logic [NIB_W-1:0] mem [DMEM_DEPTH];

   // No reset: contents survive initialization
   always_ff @(posedge clock)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clock)
   begin
      rdata_q <= mem[addr];
   end

endmodule

// *** core/fbmcu_core.sv ***
// 4-bit controller core: datapath, serial unit, I/O latches, init, APB slave.
// Assumes an APB master on clock; pins are asynchronous and synchronised here.
// Summary of operation
// - Program counter is 9 bits, steps by one each instruction cycle unless jumping.
// - Program store seen as 8 pages of 64 for paged jumps (pages 2 and 3 joined); indirect jump uses halves of 256.
// - Two return slots of 9 bits give two subroutine levels.
// - Memory is four rows of eight digits; pointer top bits pick row.
// - Digit select top bit ignored, so every digit has two aliases.
// - Exchange-step skip is true on 0/15 wrap, not on 7/8 crossing.
// - Nibble output port is loaded from digit_pick.
// - Adder writes result to work_nibble and carry to overflow_bit.
// - Output hold octet loads from memory and accumulator or program byte.
// - Feature bit two enables octet drivers; otherwise port is a readable input.
// - Swap exchanges accumulator with shift register and copies carry to gate.
// - Counter mode decrements shift register on each falling serial input edge outside a swap cycle.
// - Counter mode: clock out equals gate latch, serial out equals feature bit three.
// - Shift mode shifts left each instruction cycle except a swap cycle, serial input into bit zero.
// - Shift mode clock pulses each cycle while gate set, else held low.
// - Shift mode serial out is shift msb with feature bit three, else zero.
// - Feature bit one affects nothing.
// - Reset pin low three instruction cycles initializes; driver must hold it.
// - Optional power-up init lasts 2500 instruction cycles; can be disabled.
// - Init clears counter, accumulator, pointer, carry, ports, features; memory kept.
// - Feature nibble written only by load operation; bits act independently.
// - Instruction cycle is clock divided by 16, or by 8 or 4.
`timescale 1ns/1ps
module fbmcu_core
   import fbmcu_pkg::*;
#(
   parameter bit POR_ENABLE = 1'b1,
   parameter int POR_ICYCLES = POR_TICKS
)
(
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_DW-1:0] pwdata,
   output logic      [APB_DW-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              reset_n_pin,
   input  wire logic              serial_in_pin,
   input  wire logic [OCT_W-1:0]  octet_in,
   output logic      [OCT_W-1:0]  octet_out,
   output logic                   octet_oe,
   output logic      [NIB_W-1:0]  nibble_out_port,
   output logic      [NIB_W-1:0]  quad_io_port,
   output logic                   sync_clock_out,
   output logic                   serial_out_pin
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [PC_W-1:0]   pc_q, pc_d, rs1_q, rs1_d, rs2_q, rs2_d;
   logic [NIB_W-1:0]  a_q, a_d, shreg_q, feat_q, feat_d, nib_q, nib_d, quad_q, quad_d;
   logic [PTR_W-1:0]  ptr_q, ptr_d;
   logic [OCT_W-1:0]  hold_q, hold_d, oct_s1_q, oct_s2_q;
   logic              c_q, c_d, gate_q, gate_d, skip_q, skip_d, pend_q;
   logic              mem_we;
   logic [NIB_W-1:0]  mem_wd, m;
   logic [4:0]        sum;
   fbmcu_op_s         op_q;
   fbmcu_init_e       init_q;
   logic [1:0]        div_sel_q, low_cnt_q;
   logic [3:0]        div_cnt_q, div_last;
   logic [11:0]       por_cnt_q;
   logic              tick, first_half, init_act, exec, swap_exec;
   logic              rstn_s1_q, rstn_s2_q, si_s1_q, si_s2_q, si_s3_q, si_fall;
   logic              apb_setup, apb_wr;
   logic [APB_DW-1:0] prdata_q;
   logic              pready_q, pslverr_q, sclk_q, so_q, oe_q;
   logic [OCT_W-1:0]  oct_q;

   function automatic logic [DMEM_AW-1:0] digit_addr(input logic [PTR_W-1:0] p);
      digit_addr = {p[5:4], p[2:0]};
   endfunction

   function automatic logic [3:0] div_last_of(input logic [1:0] sel);
      case (sel)
         DIV_SEL_16: div_last_of = DIV16_LAST;
         DIV_SEL_8:  div_last_of = DIV8_LAST;
         default:    div_last_of = DIV4_LAST;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Instruction cycle timing
   // ------------------------------------------------------------
   // divide select
   assign div_last   = div_last_of(div_sel_q);
   assign tick       = (div_cnt_q >= div_last);
   assign first_half = (div_cnt_q <= (div_last >> 1));

   always_ff @(posedge clock)
   begin
      if (srst || tick)
         div_cnt_q <= 4'h0;
      else
         div_cnt_q <= div_cnt_q + 4'h1;
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // two stages first
   always_ff @(posedge clock)
   begin
      rstn_s1_q <= reset_n_pin;
      rstn_s2_q <= rstn_s1_q;
      si_s1_q   <= serial_in_pin;
      si_s2_q   <= si_s1_q;
      si_s3_q   <= si_s2_q;
      oct_s1_q  <= octet_in;
      oct_s2_q  <= oct_s1_q;
   end

   assign si_fall = si_s3_q & ~si_s2_q;

   // ------------------------------------------------------------
   // Initialization control
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (srst || rstn_s2_q)
         low_cnt_q <= 2'h0;
      else if (tick && low_cnt_q != PIN_LOW_TICKS)
         low_cnt_q <= low_cnt_q + 2'h1;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         por_cnt_q <= 12'h000;
      else if (init_q == INIT_POR && tick)
         por_cnt_q <= por_cnt_q + 12'h001;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         init_q <= POR_ENABLE ? INIT_POR : INIT_RUN;
      else if (low_cnt_q == PIN_LOW_TICKS)
         init_q <= INIT_PIN;
      else
         case (init_q)
            INIT_POR: if (tick && por_cnt_q == 12'(POR_ICYCLES - 1)) init_q <= INIT_RUN;
            INIT_PIN: if (rstn_s2_q) init_q <= INIT_RUN;
            INIT_RUN: init_q <= INIT_RUN;
            default:  init_q <= INIT_RUN;
         endcase
   end

   assign init_act = (init_q != INIT_RUN);
   assign exec     = tick && pend_q && !init_act;
   assign swap_exec = exec && !skip_q && op_q.code == OP_SWAP_SHIFT;

   // ------------------------------------------------------------
   // Data memory
   // ------------------------------------------------------------
   fbmcu_dmem u_dmem (
      .clock   (clock),
      .we      (mem_we),
      .addr    (digit_addr(ptr_q)),
      .wdata   (mem_wd),
      .rdata_q (m)
   );

   // ------------------------------------------------------------
   // Datapath next state
   // ------------------------------------------------------------
   always_comb
   begin
      pc_d = pc_q;  rs1_d = rs1_q;  rs2_d = rs2_q;  a_d = a_q;  c_d = c_q;
      ptr_d = ptr_q;  feat_d = feat_q;  nib_d = nib_q;  quad_d = quad_q;
      hold_d = hold_q;  gate_d = gate_q;  skip_d = skip_q;
      mem_we = 1'b0;  mem_wd = a_q;  sum = 5'h00;
      if (tick && !init_act)
         pc_d = pc_q + 9'h001;
      if (exec && skip_q)
         skip_d = 1'b0;
      else if (exec)
      begin
         skip_d = 1'b0;
         case (op_q.code)
            OP_ASC:
            begin
               sum = {1'b0, a_q} + {1'b0, m} + {4'h0, c_q};
               a_d = sum[3:0];  c_d = sum[4];  skip_d = sum[4];
            end
            OP_ADD:  a_d = a_q + m;
            OP_AISC:
            begin
               sum = {1'b0, a_q} + {1'b0, op_q.imm[3:0]};
               a_d = sum[3:0];  skip_d = sum[4];
            end
            OP_CLRA: a_d = 4'h0;
            OP_COMP: a_d = ~a_q;
            OP_RC:   c_d = 1'b0;
            OP_SC:   c_d = 1'b1;
            OP_XOR:  a_d = a_q ^ m;
            OP_JMP:  pc_d = op_q.addr;
            OP_JP:   pc_d = (pc_q[8:7] == PAGE_PAIR23) ? {pc_q[8:7], op_q.addr[6:0]}
                                                       : {pc_q[8:6], op_q.addr[5:0]};
            OP_JSRP:
            begin
               rs1_d = pc_q + 9'h001;  rs2_d = rs1_q;
               pc_d  = {JSRP_PAGE, op_q.addr[5:0]};
            end
            OP_JSR:
            begin
               rs1_d = pc_q + 9'h001;  rs2_d = rs1_q;  pc_d = op_q.addr;
            end
            OP_RET:  begin pc_d = rs1_q;  rs1_d = rs2_q; end
            OP_RETSK:
            begin
               pc_d = rs1_q;  rs1_d = rs2_q;  skip_d = 1'b1;
            end
            OP_JID:  pc_d = {pc_q[8], op_q.imm};
            OP_LQID: begin hold_d = op_q.imm;  rs2_d = rs1_q; end
            OP_CAMQ: hold_d = {a_q, m};
            OP_CQMA:
            begin
               mem_we = 1'b1;  mem_wd = hold_q[7:4];  a_d = hold_q[3:0];
            end
            OP_LD:   begin a_d = m;  ptr_d[5:4] = ptr_q[5:4] ^ op_q.addr[1:0]; end
            OP_XCH_INC:
            begin
               a_d = m;  mem_we = 1'b1;  ptr_d[3:0] = ptr_q[3:0] + 4'h1;
               skip_d = (ptr_q[3:0] == DIGIT_TOP);
            end
            OP_XCH_DEC:
            begin
               a_d = m;  mem_we = 1'b1;  ptr_d[3:0] = ptr_q[3:0] - 4'h1;
               skip_d = (ptr_q[3:0] == DIGIT_BOTTOM);
            end
            OP_SWAP_SHIFT:  begin a_d = shreg_q;  gate_d = c_q; end
            OP_LOAD_FEAT:  feat_d = op_q.imm[3:0];
            OP_LBI:  ptr_d = op_q.addr[5:0];
            OP_OBD:  nib_d = ptr_q[3:0];
            OP_OMG:  quad_d = m;
            OP_INL:
            begin
               mem_we = 1'b1;  mem_wd = oct_s2_q[7:4];  a_d = oct_s2_q[3:0];
            end
            OP_STII:
            begin
               mem_we = 1'b1;  mem_wd = op_q.imm[3:0];  ptr_d[3:0] = ptr_q[3:0] + 4'h1;
            end
            default: a_d = a_q;
         endcase
      end
      if (init_act)
      begin
         pc_d = 9'h000;  a_d = 4'h0;  ptr_d = 6'h00;  c_d = 1'b0;  nib_d = 4'h0;
         feat_d = 4'h0;  quad_d = 4'h0;  gate_d = 1'b1;  skip_d = 1'b0;  mem_we = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pc_q <= 9'h000;  rs1_q <= 9'h000;  rs2_q <= 9'h000;  a_q <= 4'h0;  c_q <= 1'b0;
         ptr_q <= 6'h00;  feat_q <= 4'h0;  nib_q <= 4'h0;  quad_q <= 4'h0;
         hold_q <= 8'h00;  gate_q <= 1'b1;  skip_q <= 1'b0;
      end
      else
      begin
         pc_q <= pc_d;  rs1_q <= rs1_d;  rs2_q <= rs2_d;  a_q <= a_d;  c_q <= c_d;
         ptr_q <= ptr_d;  feat_q <= feat_d;  nib_q <= nib_d;  quad_q <= quad_d;
         hold_q <= hold_d;  gate_q <= gate_d;  skip_q <= skip_d;
      end
   end

   // ------------------------------------------------------------
   // Shift register and counter
   // ------------------------------------------------------------
   // Swap wins over a same-cycle edge; that edge is then lost
   always_ff @(posedge clock)
   begin
      if (srst)
         shreg_q <= 4'h0;
      else if (swap_exec)
         shreg_q <= a_q;
      else if (feat_q[0] && si_fall)
         shreg_q <= shreg_q - 4'h1;
      else if (!feat_q[0] && tick)
         shreg_q <= {shreg_q[2:0], si_s2_q};
   end

   // ------------------------------------------------------------
   // Pin outputs
   // ------------------------------------------------------------
   // feature bit one unused
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         sclk_q <= 1'b0;  so_q <= 1'b0;  oe_q <= 1'b0;  oct_q <= 8'h00;
      end
      else
      begin
         sclk_q <= feat_q[0] ? gate_q : (gate_q && first_half);
         so_q  <= feat_q[0] ? feat_q[3] : (feat_q[3] && shreg_q[3]);
         oe_q  <= feat_q[2];
         oct_q <= hold_q;
      end
   end

   assign sync_clock_out  = sclk_q;
   assign serial_out_pin  = so_q;
   assign octet_oe        = oe_q;
   assign octet_out       = oct_q;
   assign nibble_out_port = nib_q;
   assign quad_io_port    = quad_q;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // No wait state; read data comes from a flop loaded in the setup phase
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite && pready_q;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pready_q <= 1'b0;  pslverr_q <= 1'b0;  prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= apb_setup;
         if (apb_setup)
         begin
            pslverr_q <= 1'b0;
            case (paddr)
               REG_OP:    prdata_q <= {8'h00, op_q, 1'b0, pend_q};
               REG_CORE:  prdata_q <= {4'h0, ptr_q, 2'h0, init_act, pend_q, skip_q, c_q,
                                       a_q, 3'h0, pc_q};
               REG_IO:    prdata_q <= {4'h0, quad_q, nib_q, oct_s2_q, 3'h0, gate_q,
                                       feat_q, shreg_q};
               REG_STACK: prdata_q <= {7'h00, rs2_q, 7'h00, rs1_q};
               REG_CFG:   prdata_q <= {30'h0000_0000, div_sel_q};
               REG_HOLD:  prdata_q <= {15'h0000, pc_q[8], a_q, m, hold_q};
               default:
               begin
                  prdata_q  <= 32'h0000_0000;
                  pslverr_q <= 1'b1;
               end
            endcase
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // Operation requests are refused while one is pending or during init
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pend_q <= 1'b0;  op_q <= '0;  div_sel_q <= DIV_SEL_16;
      end
      else
      begin
         if (apb_wr && paddr == REG_OP && !pend_q && !init_act)
         begin
            pend_q <= 1'b1;
            op_q   <= pwdata[21:0];
         end
         else if (exec || init_act)
            pend_q <= 1'b0;
         if (apb_wr && paddr == REG_CFG)
            div_sel_q <= pwdata[1:0];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   property p_pc_step;
      tick && !init_act && !pend_q && low_cnt_q != PIN_LOW_TICKS
         |=> pc_q == $past(pc_q) + 9'h001;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step");

   property p_jsr_push;
      exec && !skip_q && op_q.code == OP_JSR
         |=> rs1_q == $past(pc_q) + 9'h001 && rs2_q == $past(rs1_q);
   endproperty
   a_jsr_push: assert property (p_jsr_push) else $error("return push wrong");

   property p_inc_wrap;
      exec && !skip_q && op_q.code == OP_XCH_INC
         |=> skip_q == ($past(ptr_q[3:0]) == DIGIT_TOP);
   endproperty
   a_inc_wrap: assert property (p_inc_wrap) else $error("step skip wrong");

   property p_obd;
      exec && !skip_q && op_q.code == OP_OBD |=> ##1 nibble_out_port == $past(ptr_q[3:0], 2);
   endproperty
   a_obd: assert property (p_obd) else $error("nibble port not loaded");

   property p_oe;
      feat_q[2] ##1 feat_q[2] |=> octet_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("octet drivers off");

   property p_count;
      feat_q[0] && si_fall && !swap_exec |=> shreg_q == $past(shreg_q) - 4'h1;
   endproperty
   a_count: assert property (p_count) else $error("counter missed edge");

   property p_cnt_pins;
      feat_q[0] |=> sync_clock_out == $past(gate_q) && serial_out_pin == $past(feat_q[3]);
   endproperty
   a_cnt_pins: assert property (p_cnt_pins) else $error("counter mode pins wrong");

   property p_shift;
      !feat_q[0] && tick && !swap_exec |=> shreg_q == {$past(shreg_q[2:0]), $past(si_s2_q)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");

   property p_sclk_low;
      !feat_q[0] && !gate_q |=> !sync_clock_out;
   endproperty
   a_sclk_low: assert property (p_sclk_low) else $error("clock out not held low");

   property p_pin_init;
      low_cnt_q == PIN_LOW_TICKS |=> init_q == INIT_PIN ##1 pc_q == 9'h000;
   endproperty
   a_pin_init: assert property (p_pin_init) else $error("pin init missed");

   c_inc_skip: cover property (exec && op_q.code == OP_XCH_INC && ptr_q[3:0] == DIGIT_TOP);
   c_jsr:      cover property (exec && op_q.code == OP_JSR);
   c_count:    cover property (feat_q[0] && si_fall);
   c_run:      cover property (init_q == INIT_PIN ##1 init_q == INIT_RUN);

endmodule

// *** tb/fbmcu_far.sv ***
// Far-side model: serial source and the device on the octet port.
// Assumes the bench calls its tasks; the octet wire is resolved here.
`timescale 1ns/1ps
module fbmcu_far
   import fbmcu_pkg::*;
(
   input  wire logic [OCT_W-1:0] octet_out,
   input  wire logic             octet_oe,
   output logic                  serial_in_pin,
   output logic      [OCT_W-1:0] octet_in
);
   // Far device drives a fixed pattern while the core floats the port
   assign octet_in = octet_oe ? octet_out : 8'hA5;
   initial serial_in_pin = 1'h1;
   task automatic level(input logic b);
      serial_in_pin <= b;
   endtask
   task automatic pulses(input int n);
      repeat (n)
      begin
         #62.5 serial_in_pin = 1'h0;
         #62.5 serial_in_pin = 1'h1;
      end
   endtask
endmodule

// *** tb/fbmcu_core_bench.sv ***
// Self-checking bench for the controller core, driven over APB.
// Assumes a short power-up count and the far-side model on the pins.
`timescale 1ns/1ps
module fbmcu_core_bench
   import fbmcu_pkg::*;
;
   logic              clock, srst, psel, penable, pwrite, pready, pslverr;
   logic              rst_n, si, oe, sck, so, rs, p;
   logic [APB_AW-1:0] paddr;
   logic [APB_DW-1:0] pwdata, prdata, r;
   logic [OCT_W-1:0]  o_out, o_in;
   logic [NIB_W-1:0]  nib, quad, s1;
   logic [3:0]        fs [4] = '{4'h4, 4'h2, 4'h9, 4'h1};
   int                errors, n_checks, cyc, k;
   fbmcu_core #(.POR_ICYCLES(5)) dut
   (
      .clock(clock), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_n_pin(rst_n), .serial_in_pin(si), .octet_in(o_in),
      .octet_out(o_out), .octet_oe(oe), .nibble_out_port(nib), .quad_io_port(quad),
      .sync_clock_out(sck), .serial_out_pin(so)
   );
   fbmcu_far u_far (.octet_out(o_out), .octet_oe(oe), .serial_in_pin(si), .octet_in(o_in));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clock);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'h1;
      do
         @(posedge clock);
      while (pready !== 1'h1 && ++n < 50);
      if (n >= 50)
         errors++;
      r  = prdata;
      rs = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic op(input logic [4:0] c, input logic [7:0] i);
      int n = 0;
      apb(1'h1, REG_OP, {19'h0, i, c});
      do
         apb(1'h0, REG_CORE, 32'h0);
      while (r[18] !== 1'h0 && ++n < 20);
      if (n >= 20)
         errors++;
   endtask
   task automatic wait_init;
      k = 0;
      do
         apb(1'h0, REG_CORE, 32'h0);
      while (r[19] !== 1'h0 && ++k < 60);
      if (k >= 60)
         errors++;
      chk("cleared", r & 32'h0FC1F000, 32'h0);
      chk("ports", {nib, quad, oe}, 32'h0);
   endtask
   task automatic close_out;
      $display("Checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end
   // Hang guard, far above the expected run length
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         close_out();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, errors, n_checks} = '0;
      srst  = 1'h1;
      rst_n = 1'h1;
      repeat (20) @(posedge clock);
      srst <= 1'h0;
      apb(1'h0, REG_CORE, 32'h0);
      chk("por", r[19], 32'h1);
      wait_init();
      apb(1'h0, 8'h40, 32'h0);
      chk("slverr", rs, 32'h1);
      apb(1'h1, REG_CFG, 32'h2);
      apb(1'h0, REG_CFG, 32'h0);
      chk("cfg", r[1:0], 32'h2);
      op(OP_CLRA, 8'h0);
      op(OP_AISC, 8'h7);
      op(OP_AISC, 8'hB);
      op(OP_AISC, 8'h1);
      op(OP_AISC, 8'h1);
      chk("acc", r[15:12], 32'h3);
      op(OP_SC, 8'h0);
      chk("carry", r[16], 32'h1);
      foreach (fs[j])
      begin
         op(OP_LOAD_FEAT, {4'h0, fs[j]});
         apb(1'h0, REG_IO, 32'h0);
         chk("feat", r[7:4], fs[j]);
         chk("oe", oe, fs[j][2]);
         chk("so", so, fs[j][3]);
      end
      chk("oin", r[19:12], 32'hA5);
      chk("clk_cnt", sck, 32'h1);
      chk("shreg", r[3:0], 32'hF);
      s1 = 4'hC;
      u_far.pulses(3);
      repeat (8) @(posedge clock);
      op(OP_RC, 8'h0);
      op(OP_SWAP_SHIFT, 8'h0);
      chk("swap_a", r[15:12], s1);
      apb(1'h0, REG_IO, 32'h0);
      chk("swap_s", r[8:0], 32'h013);
      chk("clk_gate", sck, 32'h0);
      op(OP_LOAD_FEAT, 8'h8);
      repeat (24) @(posedge clock);
      k = 0;
      repeat (16) @(negedge clock) k += sck;
      chk("clk_off", k, 32'h0);
      apb(1'h0, REG_IO, 32'h0);
      chk("shift", r[3:0], 32'hF);
      chk("so_msb", so, 32'h1);
      op(OP_SC, 8'h0);
      op(OP_SWAP_SHIFT, 8'h0);
      k = 0;
      p = sck;
      repeat (16)
      begin
         @(negedge clock);
         k += (sck && !p);
         p = sck;
      end
      chk("clk_run", k, 32'h4);
      u_far.level(1'h0);
      repeat (24) @(posedge clock);
      apb(1'h0, REG_IO, 32'h0);
      chk("shift0", {so, r[3:0]}, 32'h0);
      rst_n <= 1'h0;
      repeat (20) @(posedge clock);
      rst_n <= 1'h1;
      wait_init();
      op(OP_STII, 8'h5);
      op(OP_OBD, 8'h0);
      chk("nib", nib, 32'h1);
      op(OP_LBI, 8'h0);
      op(OP_AISC, 8'h3);
      op(OP_CAMQ, 8'h0);
      op(OP_LOAD_FEAT, 8'h4);
      chk("oct_out", o_out, 32'h35);
      apb(1'h0, REG_IO, 32'h0);
      chk("oct_back", r[19:12], 32'h35);
      close_out();
   end
endmodule
